/* File: inc/dac_clamp_map.svh */
`ifndef DAC_CLAMP_MAP_SVH
`define DAC_CLAMP_MAP_SVH

// Register offsets
`define ADDR_DAC_SYNC         7'h15
`define ADDR_SW_CLAMP         7'h17
`define ADDR_SLEEP_ONE_SEL    7'h18
`define ADDR_SLEEP_TWO_SEL    7'h19
`define ADDR_ALARM_SEL        7'h1A
`define ADDR_TRIGGER          7'h1C
`define ADDR_CLAMP_STATUS     7'h1E
`define ADDR_EXT_RESULT_FIRST 7'h24
`define ADDR_EXT_RESULT_LAST  7'h27
`define ADDR_DAC_DATA_FIRST   7'h30
`define ADDR_DAC_DATA_LAST    7'h37

// Field positions
`define GRP_PAIR_A            0
`define GRP_PAIR_B            1
`define GRP_AUX_LSB           2
`define SEL_AMP_BIT           6
`define SEL_MANUAL_RELEASE_REQUIRED_BIT        7
`define TRIG_DAC_BIT          0

// Sizes
`define NUM_GROUPS            6
`define NUM_DACS              8
`define NUM_BIPOLAR           4
`define NUM_EXT_INPUTS        4
`define NUM_ADC_CHANNELS      15
`define DAC_BITS              12
`define REG_BITS              16

// Reset values
`define SW_CLAMP_RST          6'h3F
`define SLEEP_SEL_RST         8'h00
`define ALARM_SEL_RST         6'h00
`define DAC_SYNC_RST          8'h00
`define DAC_CODE_RST          12'h000
`define EXT_RESULT_RST        12'h000

`endif

/* File: inc/dac_clamp_pkg.sv */
package dac_clamp_pkg;

  // One register access from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // One finished conversion from the converter core
  typedef struct packed {
    logic        valid;
    logic [3:0]  channel;
    logic [11:0] code;
  } adc_result_t;

  // Converter core activity
  typedef struct packed {
    logic       ready;
    logic [3:0] sampling_channel;
  } adc_status_t;

  typedef enum logic [1:0] {
    SRC_IDLE,
    SRC_SLEEP_HELD,
    SRC_WAIT_RELEASE
  } sleep_hold_state_t;

endpackage

/* File: rtl/clamp_source_ctrl.sv */
`timescale 1ns/1ps
`include "dac_clamp_map.svh"

module clamp_source_ctrl (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     ce_i,
  input  wire logic                     sleep_pin_one_i,
  input  wire logic                     sleep_pin_two_i,
  input  wire logic [7:0]               sleep_one_sel_i,
  input  wire logic [7:0]               sleep_two_sel_i,
  input  wire logic                     alarm_out_pin_i,
  input  wire logic [`NUM_GROUPS-1:0]   alarm_sel_i,
  input  wire logic [`NUM_GROUPS-1:0]   sw_clamp_i,
  input  wire logic                     release_wr_i,
  input  wire logic [`NUM_GROUPS-1:0]   release_mask_i,
  output logic      [`NUM_GROUPS-1:0]   sleep_now_o,
  output logic      [`NUM_GROUPS-1:0]   group_clamp_o
);

  logic [`NUM_GROUPS-1:0] hold_one_reg;
  logic [`NUM_GROUPS-1:0] hold_two_reg;
  logic [`NUM_GROUPS-1:0] alarm_hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < `NUM_GROUPS; g = g + 1) begin : grp
      logic set_one;
      logic set_two;
      logic clr_one;
      logic clr_two;
      assign set_one = sleep_pin_one_i & sleep_one_sel_i[g];
      assign set_two = sleep_pin_two_i & sleep_two_sel_i[g];
      // Manual_release_required keeps the hold until the pin is low and software releases
      assign clr_one = ~sleep_pin_one_i & (~sleep_one_sel_i[`SEL_MANUAL_RELEASE_REQUIRED_BIT] |
                                           (release_wr_i & release_mask_i[g]));
      assign clr_two = ~sleep_pin_two_i & (~sleep_two_sel_i[`SEL_MANUAL_RELEASE_REQUIRED_BIT] |
                                           (release_wr_i & release_mask_i[g]));
      assign sleep_now_o[g] = set_one | set_two;

      // Set wins over clear on every hold
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          hold_one_reg[g]   <= 1'b0;
          hold_two_reg[g]   <= 1'b0;
          alarm_hold_reg[g] <= 1'b0;
        end else if (ce_i) begin
          if (set_one) begin
            hold_one_reg[g] <= 1'b1;
          end else if (clr_one) begin
            hold_one_reg[g] <= 1'b0;
          end
          if (set_two) begin
            hold_two_reg[g] <= 1'b1;
          end else if (clr_two) begin
            hold_two_reg[g] <= 1'b0;
          end
          if (alarm_out_pin_i && alarm_sel_i[g]) begin
            alarm_hold_reg[g] <= 1'b1;
          end else if (release_wr_i && release_mask_i[g]) begin
            alarm_hold_reg[g] <= 1'b0;
          end
        end
      end

      // Any live source clamps; all must drop before release
      assign group_clamp_o[g] = sw_clamp_i[g] | sleep_now_o[g] | hold_one_reg[g] |
                                hold_two_reg[g] | alarm_hold_reg[g] |
                                (alarm_out_pin_i & alarm_sel_i[g]);
    end
  endgenerate

endmodule

/* File: rtl/dac_clamp_and_adc_input_control.sv */
// Functional notes
// - Entering clamp switches the output to clamp level at once, no trigger needed.
// - Clamping leaves buffer and active registers untouched.
// - DAC data writes are accepted while clamped.
// - Leaving clamp drives the active register value regardless of sync mode.
// - Pair A, pair B and auxiliary outputs each clamp to their own level source.
// - Software clamp register has one bit per pair and per auxiliary output.
// - Writing 1 clamps the group, writing 0 returns it to normal.
// - Positive supply fault pulls all bipolar outputs to the negative supply.
// - Software clamp writes ignored for groups held by a sleep pin.
// - High sleep pin clamps every group its select register enables.
// - Each sleep select register has one enable per pair and per auxiliary output.
// - Sleep pins with their selects also drive the amplifier enable output.
// - With manual_release_required set, release needs pin low then a clamp register write.
// - With manual_release_required clear, pin going low releases the clamp by itself.
// - Alarm select register chooses groups clamped while the alarm is active.
// - Alarm-clamped groups stay clamped after the alarm returns inactive.
// - Monitor is a 12-bit converter behind a fifteen-channel multiplexer.
// - Four external inputs store straight binary codes in four consecutive registers.
// - Result code is input times 4096 over reference; stored unscaled.
// - External sampling switch stays open while the converter is ready.
// - DAC writes land in buffer; move to active at once or on trigger.
// - Reading a DAC data register returns the active register.
`timescale 1ns/1ps
`include "dac_clamp_map.svh"

module dac_clamp_and_adc_input_control (
  input  wire logic                                sys_clk_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                ce_i,
  input  wire dac_clamp_pkg::reg_req_t             reg_req_i,
  output logic      [`REG_BITS-1:0]                reg_rdata_o,
  output logic                                     reg_rvalid_o,
  input  wire logic                                sleep_pin_one_i,
  input  wire logic                                sleep_pin_two_i,
  input  wire logic                                alarm_out_pin_i,
  input  wire logic                                supply_fault_i,
  input  wire logic                                dac_trigger_i,
  input  wire dac_clamp_pkg::adc_result_t          adc_result_i,
  input  wire dac_clamp_pkg::adc_status_t          adc_status_i,
  output logic      [`NUM_DACS-1:0]                dac_clamp_o,
  output logic                                     negative_supply_clamp_o,
  output logic      [`NUM_DACS-1:0][`DAC_BITS-1:0] dac_code_o,
  output logic                                     amplifier_enable_out_o,
  output logic                                     sample_switch_closed_o
);

  logic [`NUM_GROUPS-1:0]   sw_clamp_reg;
  logic [`NUM_GROUPS-1:0]   sw_clamp_next;
  logic [7:0]               sleep_one_sel_reg;
  logic [7:0]               sleep_two_sel_reg;
  logic [`NUM_GROUPS-1:0]   alarm_sel_reg;
  logic [`NUM_DACS-1:0]     dac_sync_reg;
  logic [`DAC_BITS-1:0]     dac_buffer_reg [`NUM_DACS];
  logic [`DAC_BITS-1:0]     dac_active_reg [`NUM_DACS];
  logic [`DAC_BITS-1:0]     ext_result_reg [`NUM_EXT_INPUTS];
  logic [`NUM_GROUPS-1:0]   sleep_now;
  logic [`NUM_GROUPS-1:0]   group_clamp;
  logic [`NUM_DACS-1:0]     dac_clamp_next;
  logic                     wr_sw_clamp;
  logic                     wr_sleep_one;
  logic                     wr_sleep_two;
  logic                     wr_alarm_sel;
  logic                     wr_sync;
  logic                     trigger_pulse;
  logic                     dac_addr_hit;
  logic [2:0]               dac_index;
  logic                     ext_addr_hit;
  logic [1:0]               ext_index;
  logic [`REG_BITS-1:0]     read_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign wr_sw_clamp  = reg_req_i.wr && (reg_req_i.addr == `ADDR_SW_CLAMP);
  assign wr_sleep_one = reg_req_i.wr && (reg_req_i.addr == `ADDR_SLEEP_ONE_SEL);
  assign wr_sleep_two = reg_req_i.wr && (reg_req_i.addr == `ADDR_SLEEP_TWO_SEL);
  assign wr_alarm_sel = reg_req_i.wr && (reg_req_i.addr == `ADDR_ALARM_SEL);
  assign wr_sync      = reg_req_i.wr && (reg_req_i.addr == `ADDR_DAC_SYNC);

  assign dac_addr_hit = (reg_req_i.addr >= `ADDR_DAC_DATA_FIRST) &&
                        (reg_req_i.addr <= `ADDR_DAC_DATA_LAST);
  assign dac_index    = reg_req_i.addr[2:0];
  assign ext_addr_hit = (reg_req_i.addr >= `ADDR_EXT_RESULT_FIRST) &&
                        (reg_req_i.addr <= `ADDR_EXT_RESULT_LAST);
  assign ext_index    = reg_req_i.addr[1:0];

  // Trigger from the pin or a self-clearing register bit
  assign trigger_pulse = dac_trigger_i ||
                         (reg_req_i.wr && (reg_req_i.addr == `ADDR_TRIGGER) &&
                          reg_req_i.wdata[`TRIG_DAC_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Software clamp register

  // Bits held by a live sleep pin keep their old value
  assign sw_clamp_next = (reg_req_i.wdata[`NUM_GROUPS-1:0] & ~sleep_now) |
                         (sw_clamp_reg & sleep_now);

  // Outputs come up clamped after reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_clamp_reg <= `SW_CLAMP_RST;
    end else if (ce_i && wr_sw_clamp) begin
      sw_clamp_reg <= sw_clamp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep select, alarm select and DAC sync registers

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_one_sel_reg <= `SLEEP_SEL_RST;
      sleep_two_sel_reg <= `SLEEP_SEL_RST;
    end else if (ce_i) begin
      if (wr_sleep_one) begin
        sleep_one_sel_reg <= reg_req_i.wdata[7:0];
      end
      if (wr_sleep_two) begin
        sleep_two_sel_reg <= reg_req_i.wdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alarm_sel_reg <= `ALARM_SEL_RST;
    end else if (ce_i && wr_alarm_sel) begin
      alarm_sel_reg <= reg_req_i.wdata[`NUM_GROUPS-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_sync_reg <= `DAC_SYNC_RST;
    end else if (ce_i && wr_sync) begin
      dac_sync_reg <= reg_req_i.wdata[`NUM_DACS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp source combining

  clamp_source_ctrl u_clamp_source_ctrl (
    .sys_clk_i       (sys_clk_i),
    .reset_n_i       (reset_n_i),
    .ce_i            (ce_i),
    .sleep_pin_one_i (sleep_pin_one_i),
    .sleep_pin_two_i (sleep_pin_two_i),
    .sleep_one_sel_i (sleep_one_sel_reg),
    .sleep_two_sel_i (sleep_two_sel_reg),
    .alarm_out_pin_i (alarm_out_pin_i),
    .alarm_sel_i     (alarm_sel_reg),
    .sw_clamp_i      (sw_clamp_reg),
    .release_wr_i    (wr_sw_clamp),
    .release_mask_i  (~reg_req_i.wdata[`NUM_GROUPS-1:0]),
    .sleep_now_o     (sleep_now),
    .group_clamp_o   (group_clamp)
  );

  // Group to output mapping; supply fault overrides bipolar outputs
  always_comb begin
    dac_clamp_next[0] = group_clamp[`GRP_PAIR_A] | supply_fault_i;
    dac_clamp_next[1] = group_clamp[`GRP_PAIR_A] | supply_fault_i;
    dac_clamp_next[2] = group_clamp[`GRP_PAIR_B] | supply_fault_i;
    dac_clamp_next[3] = group_clamp[`GRP_PAIR_B] | supply_fault_i;
    dac_clamp_next[`NUM_DACS-1:`NUM_BIPOLAR] =
      group_clamp[`GRP_AUX_LSB +: `NUM_DACS-`NUM_BIPOLAR];
  end

  // One flop from source to pin; no trigger or update gate in the path
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_clamp_o             <= '1;
      negative_supply_clamp_o <= 1'b0;
    end else if (ce_i) begin
      dac_clamp_o             <= dac_clamp_next;
      negative_supply_clamp_o <= supply_fault_i;
    end
  end

  // Amplifier goes off while any enabled sleep pin is high
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      amplifier_enable_out_o <= 1'b0;
    end else if (ce_i) begin
      amplifier_enable_out_o <= ~((sleep_pin_one_i & sleep_one_sel_reg[`SEL_AMP_BIT]) |
                                  (sleep_pin_two_i & sleep_two_sel_reg[`SEL_AMP_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DAC buffer and active registers

  genvar d;
  generate
    for (d = 0; d < `NUM_DACS; d = d + 1) begin : dac
      logic data_wr;
      assign data_wr = reg_req_i.wr && dac_addr_hit && (dac_index == 3'(d));

      // Clamp state never touches these, so the old level comes back
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          dac_buffer_reg[d] <= `DAC_CODE_RST;
        end else if (ce_i && data_wr) begin
          dac_buffer_reg[d] <= reg_req_i.wdata[`DAC_BITS-1:0];
        end
      end

      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          dac_active_reg[d] <= `DAC_CODE_RST;
        end else if (ce_i) begin
          if (data_wr && !dac_sync_reg[d]) begin
            dac_active_reg[d] <= reg_req_i.wdata[`DAC_BITS-1:0];
          end else if (trigger_pulse && dac_sync_reg[d]) begin
            dac_active_reg[d] <= dac_buffer_reg[d];
          end
        end
      end

      // Code follows active always; clamp only steers the output stage
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          dac_code_o[d] <= `DAC_CODE_RST;
        end else if (ce_i) begin
          dac_code_o[d] <= dac_active_reg[d];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // External input results

  genvar e;
  generate
    for (e = 0; e < `NUM_EXT_INPUTS; e = e + 1) begin : ext
      // Codes are stored as delivered: already input * 4096 / reference
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ext_result_reg[e] <= `EXT_RESULT_RST;
        end else if (ce_i && adc_result_i.valid && (adc_result_i.channel == 4'(e))) begin
          ext_result_reg[e] <= adc_result_i.code;
        end
      end
    end
  endgenerate

  // Switch closes only when not ready and sampling one of the four external inputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_switch_closed_o <= 1'b0;
    end else if (ce_i) begin
      sample_switch_closed_o <= ~adc_status_i.ready &&
                                (adc_status_i.sampling_channel < 4'(`NUM_EXT_INPUTS));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    read_mux = '0;
    if (dac_addr_hit) begin
      read_mux[`DAC_BITS-1:0] = dac_active_reg[dac_index];
    end else if (ext_addr_hit) begin
      read_mux[`DAC_BITS-1:0] = ext_result_reg[ext_index];
    end else begin
      case (reg_req_i.addr)
        `ADDR_DAC_SYNC:      read_mux[`NUM_DACS-1:0]   = dac_sync_reg;
        `ADDR_SW_CLAMP:      read_mux[`NUM_GROUPS-1:0] = sw_clamp_reg;
        `ADDR_SLEEP_ONE_SEL: read_mux[7:0]             = sleep_one_sel_reg;
        `ADDR_SLEEP_TWO_SEL: read_mux[7:0]             = sleep_two_sel_reg;
        `ADDR_ALARM_SEL:     read_mux[`NUM_GROUPS-1:0] = alarm_sel_reg;
        `ADDR_CLAMP_STATUS:  read_mux[`NUM_DACS-1:0]   = dac_clamp_o;
        default:             read_mux                  = '0;
      endcase
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= read_mux;
      end
    end
  end

endmodule

/* File: tb/dac_clamp_asserts.sv */
`timescale 1ns/1ps
`include "dac_clamp_map.svh"

module dac_clamp_checker (
  input  wire logic                                sys_clk_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                ce_i,
  input  wire dac_clamp_pkg::reg_req_t             reg_req_i,
  input  wire logic                                reg_rvalid_o,
  input  wire logic                                sleep_pin_one_i,
  input  wire logic                                sleep_pin_two_i,
  input  wire logic                                alarm_out_pin_i,
  input  wire logic                                supply_fault_i,
  input  wire logic                                dac_trigger_i,
  input  wire dac_clamp_pkg::adc_status_t          adc_status_i,
  input  wire logic [`NUM_DACS-1:0]                dac_clamp_o,
  input  wire logic                                negative_supply_clamp_o,
  input  wire logic [`NUM_DACS-1:0][`DAC_BITS-1:0] dac_code_o,
  input  wire logic                                amplifier_enable_out_o,
  input  wire logic                                sample_switch_closed_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [7:0] sel_one_shadow;
  logic [7:0] sel_two_shadow;
  logic [5:0] alarm_shadow;

  ////////////////////////////////////////////////////////////////////////////////
  // Mirrors of the select registers; only accepted writes count
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_one_shadow <= 8'h00;
      sel_two_shadow <= 8'h00;
      alarm_shadow   <= 6'h00;
    end else if (ce_i && reg_req_i.wr) begin
      if (reg_req_i.addr == 7'h18) sel_one_shadow <= reg_req_i.wdata[7:0];
      if (reg_req_i.addr == 7'h19) sel_two_shadow <= reg_req_i.wdata[7:0];
      if (reg_req_i.addr == 7'h1A) alarm_shadow <= reg_req_i.wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_READ_ANSWER: assert property (ce_i |=> reg_rvalid_o == $past(reg_req_i.rd))
    else $error("read answer pulse wrong");
  AST_SUPPLY_FOLLOW: assert property (ce_i |=> negative_supply_clamp_o == $past(supply_fault_i))
    else $error("supply clamp does not follow fault");
  AST_SLEEP_ONE: assert property (ce_i && sleep_pin_one_i && sel_one_shadow[0] |=> dac_clamp_o[1:0] == 2'b11)
    else $error("first sleep pin did not clamp pair a");
  AST_SLEEP_TWO: assert property (ce_i && sleep_pin_two_i && sel_two_shadow[1] |=> dac_clamp_o[3:2] == 2'b11)
    else $error("second sleep pin did not clamp pair b");
  AST_AMP_ENABLE: assert property (ce_i |=> amplifier_enable_out_o == !(($past(sleep_pin_one_i) &&
    $past(sel_one_shadow[6])) || ($past(sleep_pin_two_i) && $past(sel_two_shadow[6]))))
    else $error("amplifier enable wrong");
  AST_ALARM_CLAMP: assert property (ce_i && alarm_out_pin_i && alarm_shadow[2] |=> dac_clamp_o[4])
    else $error("alarm did not clamp first unipolar output");
  AST_SW_CLAMP: assert property (ce_i && reg_req_i.wr && reg_req_i.addr == 7'h17 && reg_req_i.wdata[0]
    ##1 ce_i |=> dac_clamp_o[1:0] == 2'b11)
    else $error("clamp bit write did not clamp pair a");
  AST_SWITCH_OPEN: assert property (ce_i && adc_status_i.ready |=> !sample_switch_closed_o)
    else $error("sampling switch closed while ready");
  // Codes move only two edges after a write or trigger; clamping never touches them
  AST_CODE_HOLD: assert property (ce_i && !reg_req_i.wr && !dac_trigger_i ##1 ce_i |=> $stable(dac_code_o))
    else $error("output codes changed without write or trigger");

  cover property (sleep_pin_one_i && sel_one_shadow[0]);
  cover property (alarm_out_pin_i && alarm_shadow != 6'h00);
  cover property (reg_rvalid_o);
endmodule

bind dac_clamp_and_adc_input_control dac_clamp_checker i_dac_clamp_checker (
  .sys_clk_i               (sys_clk_i),
  .reset_n_i               (reset_n_i),
  .ce_i                    (ce_i),
  .reg_req_i               (reg_req_i),
  .reg_rvalid_o            (reg_rvalid_o),
  .sleep_pin_one_i         (sleep_pin_one_i),
  .sleep_pin_two_i         (sleep_pin_two_i),
  .alarm_out_pin_i         (alarm_out_pin_i),
  .supply_fault_i          (supply_fault_i),
  .dac_trigger_i           (dac_trigger_i),
  .adc_status_i            (adc_status_i),
  .dac_clamp_o             (dac_clamp_o),
  .negative_supply_clamp_o (negative_supply_clamp_o),
  .dac_code_o              (dac_code_o),
  .amplifier_enable_out_o  (amplifier_enable_out_o),
  .sample_switch_closed_o  (sample_switch_closed_o)
);

/* File: tb/host_model.sv */
`timescale 1ns/1ps

module host_model (
  input  wire logic              sys_clk_i,
  output dac_clamp_pkg::reg_req_t reg_req_o,
  input  wire logic [15:0]       reg_rdata_i,
  input  wire logic              reg_rvalid_i
);
  initial reg_req_o = '0;

  // Released fields are inverted so stale values are never mistaken for live ones
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk_i);
    #1;
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    ok = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps

module tb;
  logic                        clk, rst_n, ce, slp1, slp2, alarm, fault, trig;
  logic                        rvalid, negc, amp, swc, ok;
  logic [15:0]                 rdata, got;
  logic [7:0]                  clamp;
  logic [7:0][11:0]            code;
  dac_clamp_pkg::reg_req_t     req;
  dac_clamp_pkg::adc_result_t  res;
  dac_clamp_pkg::adc_status_t  stat;
  int                          num_errors, comparisons;

  dac_clamp_and_adc_input_control i_dac_clamp_and_adc_input_control (
    .sys_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .sleep_pin_one_i(slp1), .sleep_pin_two_i(slp2), .alarm_out_pin_i(alarm),
    .supply_fault_i(fault), .dac_trigger_i(trig), .adc_result_i(res), .adc_status_i(stat),
    .dac_clamp_o(clamp), .negative_supply_clamp_o(negc), .dac_code_o(code),
    .amplifier_enable_out_o(amp), .sample_switch_closed_o(swc));

  host_model i_host_model (.sys_clk_i(clk), .reg_req_o(req), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_reg(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_pin(input logic [7:0] g, input logic [7:0] e);
    check_reg({8'h00, g}, {8'h00, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host_model.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    i_host_model.read_reg(a, got, ok);
    check_reg({15'h0000, ok}, 16'h0001);
    check_reg(got, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] grp(input int g);
    return (g == 0) ? 8'h03 : (g == 1) ? 8'h0C : 8'(8'h01 << (g + 2));
  endfunction
  task automatic test_done;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Sequence needs about 170 cycles; over twenty times that is a hang
  initial begin
    #(25 * 4000);
    num_errors++;
    test_done();
  end

  initial begin
    {rst_n, slp1, slp2, alarm, fault, trig} = '0;
    ce = 1'b1;
    res = '0;
    stat = '{ready: 1'b1, sampling_channel: 4'h0};
    num_errors = 0;
    comparisons = 0;
    step(20);
    rst_n = 1'b1;
    check_pin(clamp, 8'hFF);
    rd_chk(7'h17, 16'h003F);
    rd_chk(7'h18, 16'h0000);
    for (int i = 0; i < 8; i++) wr(7'(7'h30 + i), 16'(16'h0100 + i));
    step(2);
    check_pin(clamp, 8'hFF);
    rd_chk(7'h33, 16'h0103);
    wr(7'h17, 16'h0000);
    step(2);
    check_pin(clamp, 8'h00);
    for (int i = 0; i < 8; i++) check_reg({4'h0, code[i]}, 16'(16'h0100 + i));
    // Output 0 synchronous: write waits for a trigger
    wr(7'h15, 16'h0001);
    wr(7'h30, 16'h0ABC);
    rd_chk(7'h30, 16'h0100);
    trig = 1'b1;
    step(1);
    trig = 1'b0;
    step(3);
    rd_chk(7'h30, 16'h0ABC);
    check_reg({4'h0, code[0]}, 16'h0ABC);
    // Trigger register moves buffer to active while pair a is clamped
    wr(7'h17, 16'h0001);
    wr(7'h30, 16'h0123);
    wr(7'h1C, 16'h0001);
    rd_chk(7'h1E, 16'h0003);
    rd_chk(7'h30, 16'h0123);
    check_reg({4'h0, code[0]}, 16'h0123);
    // Clock enable low freezes the clamp register
    ce = 1'b0;
    wr(7'h17, 16'h0000);
    ce = 1'b1;
    rd_chk(7'h17, 16'h0001);
    wr(7'h17, 16'h0000);
    step(2);
    check_pin(clamp, 8'h00);
    check_reg({4'h0, code[0]}, 16'h0123);
    for (int g = 0; g < 6; g++) begin
      wr(7'h17, 16'(16'h0001 << g));
      step(2);
      check_pin(clamp, grp(g));
    end
    wr(7'h17, 16'h0002);
    wr(7'h32, 16'h0555);
    step(2);
    check_pin(clamp, 8'h0C);
    wr(7'h17, 16'h0000);
    step(2);
    check_pin(clamp, 8'h00);
    check_reg({4'h0, code[2]}, 16'h0555);
    wr(7'h18, 16'h0041);
    slp1 = 1'b1;
    step(2);
    check_pin(clamp, 8'h03);
    check_pin({7'h00, amp}, 8'h00);
    wr(7'h17, 16'h0001);
    rd_chk(7'h17, 16'h0000);
    slp1 = 1'b0;
    step(3);
    check_pin(clamp, 8'h00);
    check_pin({7'h00, amp}, 8'h01);
    // Manual release bit set: pin low alone keeps the clamp
    wr(7'h19, 16'h0082);
    slp2 = 1'b1;
    step(2);
    check_pin(clamp, 8'h0C);
    slp2 = 1'b0;
    step(3);
    check_pin(clamp, 8'h0C);
    wr(7'h17, 16'h0000);
    step(2);
    check_pin(clamp, 8'h00);
    wr(7'h1A, 16'h0004);
    alarm = 1'b1;
    step(2);
    check_pin(clamp, 8'h10);
    alarm = 1'b0;
    step(3);
    check_pin(clamp, 8'h10);
    wr(7'h17, 16'h0000);
    step(2);
    check_pin(clamp, 8'h00);
    fault = 1'b1;
    step(2);
    check_pin({7'h00, negc}, 8'h01);
    fault = 1'b0;
    step(2);
    check_pin({7'h00, negc}, 8'h00);
    for (int c = 0; c < 5; c++) begin
      res = '{valid: 1'b1, channel: 4'(c), code: 12'(12'hF00 + c)};
      step(1);
    end
    res = '0;
    wr(7'h24, 16'h0FFF);
    for (int c = 0; c < 4; c++) rd_chk(7'(7'h24 + c), 16'(16'h0F00 + c));
    stat = '{ready: 1'b0, sampling_channel: 4'h2};
    step(2);
    check_pin({7'h00, swc}, 8'h01);
    stat.sampling_channel = 4'h5;
    step(2);
    check_pin({7'h00, swc}, 8'h00);
    stat = '{ready: 1'b1, sampling_channel: 4'h2};
    step(2);
    check_pin({7'h00, swc}, 8'h00);
    test_done();
  end
endmodule
